// >>> hw/output_select_pkg.sv
package output_select_pkg;

  localparam int          SEL_WIDTH      = 6;
  localparam int          REG_WIDTH      = 16;
  localparam int          PIN_COUNT      = 4;
  localparam int          SOURCE_COUNT   = 26;
  localparam int          ADDR_WIDTH     = 4;

  // register byte addresses (one aligned 32-bit word each)
  localparam logic [3:0]  ADDR_SEL_64_65 = 4'h0;
  localparam logic [3:0]  ADDR_SEL_66_67 = 4'h4;
  localparam logic [3:0]  ADDR_PIN_STATE = 4'h8;

  // field positions inside a selector register
  localparam int          LOW_FIELD_LSB  = 0;
  localparam int          HIGH_FIELD_LSB = 8;

  localparam logic [5:0]  SEL_RESET      = 6'h00;
  localparam logic [31:0] UNMAPPED_READ  = 32'h0000_0000;

  // function selector codes
  localparam logic [5:0]  FN_DEFAULT_PORT   = 6'h00;
  localparam logic [5:0]  FN_UART1_TX       = 6'h01;
  localparam logic [5:0]  FN_UART1_RTS      = 6'h02;
  localparam logic [5:0]  FN_SPI1_SDO       = 6'h05;
  localparam logic [5:0]  FN_SPI1_SCK       = 6'h06;
  localparam logic [5:0]  FN_SPI1_CS        = 6'h07;
  localparam logic [5:0]  FN_REFCLK         = 6'h0E;
  localparam logic [5:0]  FN_CCP1           = 6'h0F;
  localparam logic [5:0]  FN_CCP2           = 6'h10;
  localparam logic [5:0]  FN_CCP3           = 6'h11;
  localparam logic [5:0]  FN_CCP4           = 6'h12;
  localparam logic [5:0]  FN_CMP1           = 6'h17;
  localparam logic [5:0]  FN_CMP2           = 6'h18;
  localparam logic [5:0]  FN_CMP3           = 6'h19;
  localparam logic [5:0]  FN_PWM4_HIGH      = 6'h22;
  localparam logic [5:0]  FN_PWM4_LOW       = 6'h23;
  localparam logic [5:0]  FN_PWM_EVENT_A    = 6'h24;
  localparam logic [5:0]  FN_PWM_EVENT_B    = 6'h25;
  localparam logic [5:0]  FN_ENCODER_CMP    = 6'h26;
  localparam logic [5:0]  FN_LOGIC_CELL1    = 6'h28;
  localparam logic [5:0]  FN_LOGIC_CELL2    = 6'h29;
  localparam logic [5:0]  FN_PWM_EVENT_C    = 6'h2C;
  localparam logic [5:0]  FN_PWM_EVENT_D    = 6'h2D;
  localparam logic [5:0]  FN_TRIGGER_24     = 6'h2E;
  localparam logic [5:0]  FN_TRIGGER_25     = 6'h2F;
  localparam logic [5:0]  FN_LOGIC_CELL3    = 6'h32;

  // bit index of each source in the peripheral output vector
  localparam int          SRC_UART1_TX    = 0;
  localparam int          SRC_UART1_RTS   = 1;
  localparam int          SRC_SPI1_SDO    = 2;
  localparam int          SRC_SPI1_SCK    = 3;
  localparam int          SRC_SPI1_CS     = 4;
  localparam int          SRC_REFCLK      = 5;
  localparam int          SRC_CCP1        = 6;
  localparam int          SRC_CCP2        = 7;
  localparam int          SRC_CCP3        = 8;
  localparam int          SRC_CCP4        = 9;
  localparam int          SRC_CMP1        = 10;
  localparam int          SRC_CMP2        = 11;
  localparam int          SRC_CMP3        = 12;
  localparam int          SRC_PWM4_HIGH   = 13;
  localparam int          SRC_PWM4_LOW    = 14;
  localparam int          SRC_PWM_EVENT_A = 15;
  localparam int          SRC_PWM_EVENT_B = 16;
  localparam int          SRC_ENCODER_CMP = 17;
  localparam int          SRC_LOGIC_CELL1 = 18;
  localparam int          SRC_LOGIC_CELL2 = 19;
  localparam int          SRC_PWM_EVENT_C = 20;
  localparam int          SRC_PWM_EVENT_D = 21;
  localparam int          SRC_TRIGGER_24  = 22;
  localparam int          SRC_TRIGGER_25  = 23;
  localparam int          SRC_LOGIC_CELL3 = 24;
  localparam int          SRC_SPARE       = 25;

  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_ANSWER
  } bus_state_type;

endpackage

// >>> hw/pin_function_mux.sv
`timescale 1ns/100ps
module pin_function_mux
  import output_select_pkg::*;
(
  input  wire logic [SEL_WIDTH-1:0]    function_sel,
  input  wire logic [SOURCE_COUNT-1:0] peripheral_out,
  input  wire logic                    port_data,
  input  wire logic                    port_direction_setting,
  output logic                         pin_level,
  output logic                         pin_drive
);

  logic       routed;
  logic       routed_level;

  always_comb begin
    routed       = 1'b1;
    routed_level = 1'b0;
    case (function_sel)
      FN_UART1_TX:    routed_level = peripheral_out[SRC_UART1_TX];
      FN_UART1_RTS:   routed_level = peripheral_out[SRC_UART1_RTS];
      FN_SPI1_SDO:    routed_level = peripheral_out[SRC_SPI1_SDO];
      FN_SPI1_SCK:    routed_level = peripheral_out[SRC_SPI1_SCK];
      FN_SPI1_CS:     routed_level = peripheral_out[SRC_SPI1_CS];
      FN_REFCLK:      routed_level = peripheral_out[SRC_REFCLK];
      FN_CCP1:        routed_level = peripheral_out[SRC_CCP1];
      FN_CCP2:        routed_level = peripheral_out[SRC_CCP2];
      FN_CCP3:        routed_level = peripheral_out[SRC_CCP3];
      FN_CCP4:        routed_level = peripheral_out[SRC_CCP4];
      FN_CMP1:        routed_level = peripheral_out[SRC_CMP1];
      FN_CMP2:        routed_level = peripheral_out[SRC_CMP2];
      FN_CMP3:        routed_level = peripheral_out[SRC_CMP3];
      FN_PWM4_HIGH:   routed_level = peripheral_out[SRC_PWM4_HIGH];
      FN_PWM4_LOW:    routed_level = peripheral_out[SRC_PWM4_LOW];
      FN_PWM_EVENT_A: routed_level = peripheral_out[SRC_PWM_EVENT_A];
      FN_PWM_EVENT_B: routed_level = peripheral_out[SRC_PWM_EVENT_B];
      FN_PWM_EVENT_C: routed_level = peripheral_out[SRC_PWM_EVENT_C];
      FN_PWM_EVENT_D: routed_level = peripheral_out[SRC_PWM_EVENT_D];
      FN_ENCODER_CMP: routed_level = peripheral_out[SRC_ENCODER_CMP];
      FN_LOGIC_CELL1: routed_level = peripheral_out[SRC_LOGIC_CELL1];
      FN_LOGIC_CELL2: routed_level = peripheral_out[SRC_LOGIC_CELL2];
      FN_LOGIC_CELL3: routed_level = peripheral_out[SRC_LOGIC_CELL3];
      FN_TRIGGER_24:  routed_level = peripheral_out[SRC_TRIGGER_24];
      FN_TRIGGER_25:  routed_level = peripheral_out[SRC_TRIGGER_25];
      default:        routed       = 1'b0;
    endcase
  end

  // a routed function owns the buffer whatever the direction bit says
  always_comb begin
    if (routed) begin
      pin_level = routed_level;
      pin_drive = 1'b1;
    end else begin
      pin_level = port_data;
      pin_drive = !port_direction_setting;
    end
  end

endmodule // pin_function_mux

// >>> hw/remappable_output_select.sv
`timescale 1ns/100ps
// Contract
// - Six-bit selector per pin; zero leaves the pin to its port logic.
// - Codes 1 and 2 route first UART transmit and request-to-send.
// - Codes 5, 6, 7 route first SPI data, clock and chip select.
// - Code 14 routes the reference clock output.
// - Codes 15 to 18 route capture/compare units one to four.
// - Codes 23, 24, 25 route comparators one, two, three.
// - Codes 34 and 35 route PWM generator four high and low sides.
// - Codes 36, 37, 44, 45 route PWM events A, B, C, D.
// - Code 38 routes the encoder comparator output.
// - Codes 40, 41, 50 route logic cells one, two, three.
// - Codes 46 and 47 route primary core trigger outputs 24 and 25.
// - First register: bits 13-8 pin 65, bits 5-0 pin 64.
// - Second register: bits 13-8 pin 67, bits 5-0 pin 66.
// - Bits 15-14 and 7-6 ignore writes and read zero.
// - A routed function drives the pin regardless of direction setting.
module remappable_output_select
  import output_select_pkg::*;
(
  input  wire logic                    clk_sys,
  input  wire logic                    rst_b,
  input  wire logic [ADDR_WIDTH-1:0]   avs_address,
  input  wire logic                    avs_read,
  input  wire logic                    avs_write,
  input  wire logic [31:0]             avs_writedata,
  input  wire logic [3:0]              avs_byteenable,
  output logic [31:0]                  avs_readdata,
  output logic                         avs_waitrequest,
  input  wire logic [SOURCE_COUNT-1:0] peripheral_out,
  input  wire logic [PIN_COUNT-1:0]    port_data,
  input  wire logic [PIN_COUNT-1:0]    port_direction_setting,
  output logic [PIN_COUNT-1:0]         remappable_output_pin,
  output logic [PIN_COUNT-1:0]         remappable_output_pin_oe
);

  bus_state_type               bus_state;
  logic [SEL_WIDTH-1:0]        pin_sel [PIN_COUNT];
  logic [PIN_COUNT-1:0]        next_pin_level;
  logic [PIN_COUNT-1:0]        next_pin_drive;
  logic                        access;
  logic                        write_low_lane;
  logic                        write_high_lane;

  assign access          = avs_read || avs_write;
  assign write_low_lane  = avs_write && avs_byteenable[0] && bus_state == BUS_IDLE;
  assign write_high_lane = avs_write && avs_byteenable[1] && bus_state == BUS_IDLE;

  // every access is answered one cycle after it is presented
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      bus_state <= BUS_IDLE;
    end else begin
      case (bus_state)
        BUS_IDLE:   bus_state <= access ? BUS_ANSWER : BUS_IDLE;
        BUS_ANSWER: bus_state <= BUS_IDLE;
        default:    bus_state <= BUS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !(access && bus_state == BUS_IDLE);
    end
  end

  // pins 64/65 in register 0, 66/67 in register 1; even pin in low field
  generate
    for (genvar p = 0; p < PIN_COUNT; p++) begin : g_sel
      localparam logic [3:0] REG_ADDR = (p < 2) ? ADDR_SEL_64_65 : ADDR_SEL_66_67;
      localparam bit         HIGH     = (p % 2) == 1;
      localparam int         LSB      = HIGH ? HIGH_FIELD_LSB : LOW_FIELD_LSB;
      logic lane_ok;
      assign lane_ok = HIGH ? write_high_lane : write_low_lane;
      always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
          pin_sel[p] <= SEL_RESET;
        end else if (lane_ok && avs_address == REG_ADDR) begin
          pin_sel[p] <= avs_writedata[LSB +: SEL_WIDTH];
        end
      end

      pin_function_mux u_mux (
        .function_sel           (pin_sel[p]),
        .peripheral_out         (peripheral_out),
        .port_data              (port_data[p]),
        .port_direction_setting (port_direction_setting[p]),
        .pin_level              (next_pin_level[p]),
        .pin_drive              (next_pin_drive[p])
      );
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      avs_readdata <= UNMAPPED_READ;
    end else if (avs_read && bus_state == BUS_IDLE) begin
      case (avs_address)
        ADDR_SEL_64_65: avs_readdata <= {16'h0000, 2'b00, pin_sel[1], 2'b00, pin_sel[0]};
        ADDR_SEL_66_67: avs_readdata <= {16'h0000, 2'b00, pin_sel[3], 2'b00, pin_sel[2]};
        ADDR_PIN_STATE: avs_readdata <= {24'h000000, remappable_output_pin_oe,
                                         remappable_output_pin};
        default:        avs_readdata <= UNMAPPED_READ;
      endcase
    end
  end

  // registered pin drive keeps outputs glitch free; costs one cycle of latency
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      remappable_output_pin    <= '0;
      remappable_output_pin_oe <= '0;
    end else begin
      remappable_output_pin    <= next_pin_level;
      remappable_output_pin_oe <= next_pin_drive;
    end
  end

endmodule // remappable_output_select

// >>> test/output_select_sva.sv
`timescale 1ns/100ps
module output_select_checker
  import output_select_pkg::*;
(
  input wire logic                    clk_sys,
  input wire logic                    rst_b,
  input wire logic [ADDR_WIDTH-1:0]   avs_address,
  input wire logic                    avs_read,
  input wire logic                    avs_write,
  input wire logic [31:0]             avs_readdata,
  input wire logic                    avs_waitrequest,
  input wire logic [PIN_COUNT-1:0]    port_direction_setting,
  input wire logic [PIN_COUNT-1:0]    remappable_output_pin_oe
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  logic ans_rd;
  assign ans_rd = avs_read && !avs_waitrequest;
  a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("access not answered after one cycle");
  a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_wait_idle: assert property (!(avs_read || avs_write) && avs_waitrequest |=> avs_waitrequest)
    else $error("answer without a request");
  a_reserved_zero: assert property (ans_rd && avs_address inside {4'h0, 4'h4} |->
    avs_readdata[31:14] == 18'h0 && avs_readdata[7:6] == 2'h0)
    else $error("unimplemented selector bits read nonzero");
  a_status_upper: assert property (ans_rd && avs_address == 4'h8 |-> avs_readdata[31:8] == 24'h0)
    else $error("status upper bits nonzero");
  a_unmapped_zero: assert property (ans_rd && !(avs_address inside {4'h0, 4'h4, 4'h8})
    |-> avs_readdata == 32'h0)
    else $error("unmapped read nonzero");
  a_output_drive: assert property ($past(rst_b) |->
    &(remappable_output_pin_oe | $past(port_direction_setting)))
    else $error("output pin not driven");
  a_data_hold: assert property ($past(rst_b) && !$past(avs_read) |-> $stable(avs_readdata))
    else $error("read data changed without a read");
  a_reset_state: assert property ($rose(rst_b) |-> avs_waitrequest && avs_readdata == 32'h0)
    else $error("bus outputs not cleared by reset");
  c_write_done: cover property (avs_write && !avs_waitrequest);
  c_read_done: cover property (ans_rd);
  c_pin_released: cover property (remappable_output_pin_oe != 4'hF);
endmodule // output_select_checker
bind remappable_output_select output_select_checker u_output_select_checker (.clk_sys,
  .rst_b, .avs_address, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest,
  .port_direction_setting, .remappable_output_pin_oe);

// >>> test/pad_load.sv
`timescale 1ns/100ps
module pad_load
  import output_select_pkg::*;
(
  input  wire logic [PIN_COUNT-1:0] remappable_output_pin,
  input  wire logic [PIN_COUNT-1:0] remappable_output_pin_oe,
  output logic      [PIN_COUNT-1:0] pad_level
);
  // an undriven pad falls to the board pull-down, never the last level
  assign pad_level = remappable_output_pin & remappable_output_pin_oe;
endmodule // pad_load

// >>> test/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import output_select_pkg::*;
  logic                    clk_sys = 1'b0;
  logic                    rst_b = 1'b0;
  logic [ADDR_WIDTH-1:0]   avs_address = 4'h0;
  logic                    avs_read = 1'b0;
  logic                    avs_write = 1'b0;
  logic [31:0]             avs_writedata = 32'h0;
  logic [3:0]              avs_byteenable = 4'hF;
  logic [31:0]             avs_readdata;
  logic                    avs_waitrequest;
  logic [SOURCE_COUNT-1:0] peripheral_out = '0;
  logic [PIN_COUNT-1:0]    port_data = 4'h0;
  logic [PIN_COUNT-1:0]    port_direction_setting = 4'hF;
  logic [PIN_COUNT-1:0]    remappable_output_pin;
  logic [PIN_COUNT-1:0]    remappable_output_pin_oe;
  logic [PIN_COUNT-1:0]    pad_level;
  logic [5:0]              codes [25] = '{6'h01, 6'h02, 6'h05, 6'h06, 6'h07, 6'h0E, 6'h0F,
    6'h10, 6'h11, 6'h12, 6'h17, 6'h18, 6'h19, 6'h22, 6'h23, 6'h24, 6'h25, 6'h26, 6'h28,
    6'h29, 6'h2C, 6'h2D, 6'h2E, 6'h2F, 6'h32};
  logic [5:0]              unused_codes [3] = '{6'h00, 6'h03, 6'h3F};
  int                      errors = 0;
  int                      comparisons = 0;
  always #25 clk_sys = ~clk_sys;
  remappable_output_select u_remappable_output_select (.clk_sys, .rst_b, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .peripheral_out, .port_data, .port_direction_setting, .remappable_output_pin,
    .remappable_output_pin_oe);
  pad_load u_pad_load (.remappable_output_pin, .remappable_output_pin_oe, .pad_level);
  task end_of_test;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // request held until the edge that samples waitrequest low
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be,
           output logic [31:0] q);
    int   n;
    logic ans;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_read <= ~wr;
    avs_write <= wr;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    // an answer on the last allowed edge is still an answer
    ans = (avs_waitrequest === 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys);
    if (!ans) begin
      errors++;
      end_of_test;
    end
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, 4'hF, q);
  endtask
  task rd(input string nm, input logic [3:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, 4'hF, q);
    chk(nm, q, e);
  endtask
  initial begin
    logic [31:0] d;
    int          p;
    repeat (16) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    rd("sel_64_65", ADDR_SEL_64_65, 32'h0);
    rd("sel_66_67", ADDR_SEL_66_67, 32'h0);
    wr(ADDR_SEL_64_65, 32'hFFFF_FFFF);
    rd("sel_64_65", ADDR_SEL_64_65, 32'h0000_3F3F);
    wr(ADDR_SEL_66_67, 32'hFFFF_E9EA);
    rd("sel_66_67", ADDR_SEL_66_67, 32'h0000_292A);
    bus(1'b1, ADDR_SEL_64_65, 32'h0, 4'h2, d);
    rd("lane1 only", ADDR_SEL_64_65, 32'h0000_003F);
    bus(1'b1, ADDR_SEL_66_67, 32'h0, 4'h1, d);
    rd("lane0 only", ADDR_SEL_66_67, 32'h0000_2900);
    wr(4'hC, 32'hFFFF_FFFF);
    rd("unmapped", 4'hC, 32'h0);
    port_data <= 4'b0011;
    port_direction_setting <= 4'b0101;
    peripheral_out <= '1;
    for (int k = 0; k < 3; k++) begin
      d = {18'h0, unused_codes[k], 2'b00, unused_codes[k]};
      wr(ADDR_SEL_64_65, d);
      wr(ADDR_SEL_66_67, d);
      repeat (2) @(posedge clk_sys);
      chk("pin", 32'(remappable_output_pin), 32'h3);
      chk("oe", 32'(remappable_output_pin_oe), 32'hA);
      chk("pad", 32'(pad_level), 32'h2);
      rd("status", ADDR_PIN_STATE, 32'h0000_00A3);
    end
    port_data <= 4'hF;
    port_direction_setting <= 4'hF;
    // one code per pass, rotated over all four pins
    for (int k = 0; k < 25; k++) begin
      p = k % 4;
      d = 32'(codes[k]) << (8 * (p % 2));
      wr(ADDR_SEL_64_65, (p < 2) ? d : 32'h0);
      wr(ADDR_SEL_66_67, (p < 2) ? 32'h0 : d);
      peripheral_out <= 26'(1) << k;
      repeat (2) @(posedge clk_sys);
      chk("oe", 32'(remappable_output_pin_oe), 32'(1) << p);
      chk("pad high", 32'(pad_level), 32'(1) << p);
      peripheral_out <= ~(26'(1) << k);
      repeat (2) @(posedge clk_sys);
      chk("pad low", 32'(pad_level), 32'h0);
    end
    rst_b <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    rd("sel_64_65", ADDR_SEL_64_65, 32'h0);
    chk("oe", 32'(remappable_output_pin_oe), 32'h0);
    end_of_test;
  end
endmodule // tb_top
